// >>> bench/iopx_assertions.sv
// Port-level checks of the I/O port and external interrupt block
`timescale 1ns/100ps
module iopx_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire iopx_pkg::iopx_apb_req_s apb_req,
  input wire iopx_pkg::iopx_apb_rsp_s apb_rsp,
  input wire logic [3:0][7:0] pin_in,
  input wire iopx_pkg::iopx_pin_drv_s pin_drv,
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq_req,
  input wire logic cpu_run
);
  logic [4:0] sns_reg;
  logic [3:0] en_reg;
  logic wa;
  logic on0;
  assign wa = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign on0 = cpu_run && en_reg[0] && en_reg[3];
  // ============================================================
  // Shadow of sense and enable writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sns_reg <= 5'h00;
      en_reg <= 4'h0;
    end else begin
      if (wa && apb_req.paddr == 8'h30) begin
        sns_reg <= apb_req.pwdata[4:0];
      end
      if (wa && apb_req.paddr == 8'h34) begin
        en_reg <= {apb_req.pwdata[7], apb_req.pwdata[2:0]};
      end
    end
  end
  // ============================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_reset_quiet: assert property ($rose(rstn) |->
    pin_drv == '0 && irq_req == 3'h0 && cpu_run) else $error("reset outputs");
  a_dir_lands: assert property (wa && apb_req.paddr == 8'h28 |=>
    pin_drv.oe[3] == $past(apb_req.pwdata[7:0])) else $error("direction");
  a_latch_lands: assert property (wa && apb_req.paddr == 8'h00 |=>
    pin_drv.out[0] == $past(apb_req.pwdata[7:0])) else $error("latch");
  a_unmapped_err: assert property (apb_req.psel && apb_req.penable &&
    apb_req.paddr > 8'h3c |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped");
  a_level_hold: assert property ((on0 && sns_reg[1:0] == 2'h0 && !pin_in[3][2])[*3]
    |-> irq_req[0]) else $error("level request");
  a_fall_seen: assert property (on0 && sns_reg[1:0] == 2'h2 && $fell(pin_in[3][2])
    |-> ##[1:4] irq_req[0]) else $error("falling edge");
  a_ack_clears: assert property ((sns_reg[1:0] != 2'h0 && $stable(pin_in[3][2]))[*5]
    ##0 irq_ack[0] |=> !irq_req[0]) else $error("ack");
  a_async_rise: assert property (cpu_run && sns_reg[4] && en_reg[2] && en_reg[3] &&
    $rose(pin_in[1][2]) |-> ##[0:4] irq_req[2]) else $error("async edge");
  a_level_noflag: assert property (apb_req.psel && apb_req.penable &&
    apb_req.paddr == 8'h38 && sns_reg[1:0] == 2'h0 |-> !apb_rsp.prdata[0]) else $error("flag");
endmodule

bind iopx_top iopx_assertions chk_u (.clk(clk), .rstn(rstn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pin_in(pin_in), .pin_drv(pin_drv), .irq_ack(irq_ack),
  .irq_req(irq_req), .cpu_run(cpu_run));

// >>> bench/iopx_board.sv
// Board model: resolves port pins from device drive and board levels
`timescale 1ns/100ps
module iopx_board (
  input wire iopx_pkg::iopx_pin_drv_s pin_drv,
  input wire logic [3:0][7:0] board_lvl,
  output logic [3:0][7:0] pin_in
);
  // Driven pins show the latch, released pins the board level
  assign pin_in = (pin_drv.oe & pin_drv.out) | (~pin_drv.oe & board_lvl);
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the I/O port and external interrupt block
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic rstn;
  iopx_pkg::iopx_apb_req_s req;
  iopx_pkg::iopx_apb_rsp_s rsp;
  iopx_pkg::iopx_pin_drv_s drv;
  logic [3:0][7:0] lvl;
  logic [3:0][7:0] pins;
  logic [2:0] ack;
  logic [2:0] irq;
  logic run;
  logic [3:0] obs;
  logic [31:0] r;
  logic e;
  int fail_count;
  int samples_checked;
  int cyc;
  assign obs = {run, irq};
  iopx_top dut_u (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .pin_in(pins),
    .pin_drv(drv), .irq_ack(ack), .irq_req(irq), .cpu_run(run));
  iopx_board board_u (.pin_drv(drv), .board_lvl(lvl), .pin_in(pins));
  always #25 clk = ~clk;
  // ============================================================
  // Report and timeout
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ============================================================
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h0, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wt(input int i, input logic v, input int n);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (obs[i] !== v && k < n);
    chk(32'(obs[i]), 32'(v));
    // Hand back on a rising edge so that pin stimulus after a wait stays edge-aligned
    @(posedge clk);
  endtask
  task automatic pulse();
    @(posedge clk);
    ack <= 3'h1;
    @(posedge clk);
    ack <= 3'h0;
  endtask
  // Set sense, clear flags, move one line, check request and flag
  task automatic edg(input logic [7:0] s, input int l, input logic v, input logic ei,
    input logic ef);
    wr(8'h30, s);
    wr(8'h38, 8'h07);
    if (l == 2) lvl[1][2] <= v;
    else lvl[3][2 + l] <= v;
    repeat (6) @(negedge clk);
    wt(l, ei, 1);
    rd(8'h38, 8'(ef) << l);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    req = '0;
    lvl = {4{8'hc3}};
    ack = 3'h0;
    cyc = 0;
    fail_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      rd(8'(12 * p), 8'h00);
      rd(8'(12 * p + 4), 8'h00);
      wr(8'(12 * p), 8'h5a ^ 8'(p));
      wr(8'(12 * p + 4), 8'h0f);
      rd(8'(12 * p), 8'h5a ^ 8'(p));
      rd(8'(12 * p + 4), 8'h0f);
      wr(8'(12 * p + 8), 8'hff);
      rd(8'(12 * p + 8), 8'hca ^ 8'(p));
      chk(32'(drv.oe[p]), 32'h0f);
      wr(8'(12 * p + 4), 8'h00);
    end
    rd(8'h40, 8'h00);
    chk(32'(e), 32'h1);
    lvl <= {4{8'hff}};
    wr(8'h34, 8'h87);
    edg(8'h02, 0, 1'b0, 1'b1, 1'b1);
    edg(8'h03, 0, 1'b1, 1'b1, 1'b1);
    edg(8'h03, 0, 1'b0, 1'b0, 1'b0);
    edg(8'h01, 0, 1'b1, 1'b1, 1'b1);
    edg(8'h01, 0, 1'b0, 1'b1, 1'b1);
    edg(8'h08, 1, 1'b0, 1'b1, 1'b1);
    edg(8'h0c, 1, 1'b1, 1'b1, 1'b1);
    edg(8'h00, 2, 1'b0, 1'b1, 1'b1);
    edg(8'h10, 2, 1'b1, 1'b1, 1'b1);
    edg(8'h10, 2, 1'b0, 1'b0, 1'b0);
    wr(8'h34, 8'h07);
    edg(8'h0a, 1, 1'b0, 1'b0, 1'b1);
    wr(8'h34, 8'h87);
    edg(8'h00, 0, 1'b0, 1'b1, 1'b0);
    pulse();
    repeat (100) @(posedge clk);
    wt(0, 1'b1, 1);
    edg(8'h03, 0, 1'b1, 1'b1, 1'b1);
    pulse();
    wt(0, 1'b0, 4);
    // ============================================================
    // Software interrupt through a driven pin
    lvl[3][3] <= 1'b1;
    wr(8'h24, 8'h04);
    wr(8'h28, 8'h04);
    wr(8'h30, 8'h02);
    wr(8'h38, 8'h07);
    wr(8'h24, 8'h00);
    wt(0, 1'b1, 12);
    wr(8'h28, 8'h00);
    // ============================================================
    // Sleep and wake-up
    wr(8'h38, 8'h07);
    wr(8'h3c, 8'h42);
    wt(3, 1'b0, 4);
    lvl[3][2] <= 1'b0;
    wt(3, 1'b1, 12);
    lvl[3][2] <= 1'b1;
    lvl[1][2] <= 1'b1;
    wr(8'h38, 8'h07);
    wr(8'h3c, 8'h43);
    lvl[3][2] <= 1'b0;
    repeat (200) @(posedge clk);
    wt(3, 1'b0, 1);
    lvl[1][2] <= 1'b0;
    wt(3, 1'b1, 400);
    lvl[3][2] <= 1'b1;
    wr(8'h30, 8'h00);
    wr(8'h38, 8'h07);
    wr(8'h3c, 8'h43);
    lvl[3][2] <= 1'b0;
    repeat (10) @(posedge clk);
    wt(3, 1'b0, 1);
    wt(3, 1'b1, 400);
    wt(0, 1'b1, 1);
    lvl[3][2] <= 1'b1;
    wr(8'h3c, 8'h43);
    lvl[3][2] <= 1'b0;
    repeat (70) @(posedge clk);
    lvl[3][2] <= 1'b1;
    wt(3, 1'b1, 400);
    wt(0, 1'b0, 1);
    conclude();
  end
endmodule

// >>> core/iopx_cfg.svh
// Register map, field positions and timing counts of the I/O port block
`ifndef IOPX_CFG_SVH
`define IOPX_CFG_SVH

// ============================================================
// Register map (byte addresses)
`define IOPX_PORT_STRIDE 8'h0c
`define IOPX_OFS_LATCH 8'h00
`define IOPX_OFS_DIR 8'h04
`define IOPX_OFS_PINS 8'h08
`define IOPX_ADDR_SENSE 8'h30
`define IOPX_ADDR_ENABLE 8'h34
`define IOPX_ADDR_FLAGS 8'h38
`define IOPX_ADDR_POWER 8'h3c

// ============================================================
// Reset values
`define IOPX_LATCH_RST 8'h00
`define IOPX_DIR_RST 8'h00
`define IOPX_SENSE_RST 4'h0
`define IOPX_STARTUP_RST 4'h4

// ============================================================
// Field positions
`define IOPX_SENSE_FIRST_LSB 0
`define IOPX_SENSE_SECOND_LSB 2
`define IOPX_ASYNC_SEL_BIT 4
`define IOPX_GLOBAL_EN_BIT 7
`define IOPX_PWR_MODE_BIT 0
`define IOPX_PWR_GO_BIT 1
`define IOPX_PWR_STARTUP_LSB 4
`define IOPX_PWR_STATE_LSB 8

// ============================================================
// Sense encodings of the two clocked lines
`define IOPX_SENSE_LOW 2'b00
`define IOPX_SENSE_ANY 2'b01
`define IOPX_SENSE_FALL 2'b10
`define IOPX_SENSE_RISE 2'b11

// ============================================================
// Interrupt pin positions (port index, bit)
`define IOPX_FIRST_PORT 3
`define IOPX_FIRST_BIT 2
`define IOPX_SECOND_PORT 3
`define IOPX_SECOND_BIT 3
`define IOPX_ASYNC_PORT 1
`define IOPX_ASYNC_BIT 2

// ============================================================
// Timing
`define IOPX_CLK_PERIOD_NS 50
`define IOPX_WDT_PERIOD_NS 1000
`define IOPX_WDT_CYCLES (`IOPX_WDT_PERIOD_NS / `IOPX_CLK_PERIOD_NS)

`endif

// >>> core/iopx_pkg.sv
// Types shared by the I/O port and external interrupt block
package iopx_pkg;

  // ============================================================
  // Power states
  typedef enum logic [1:0] {
    IOPX_ST_AWAKE = 2'b00,
    IOPX_ST_IDLE = 2'b01,
    IOPX_ST_DEEP = 2'b10,
    IOPX_ST_START = 2'b11
  } iopx_state_e;

  // ============================================================
  // Bus and pin carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } iopx_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } iopx_apb_rsp_s;

  typedef struct packed {
    logic [3:0][7:0] out;
    logic [3:0][7:0] oe;
  } iopx_pin_drv_s;

  // ============================================================
  // Whole block state
  typedef struct packed {
    logic [3:0][7:0] latch;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] sync1;
    logic [3:0][7:0] sync2;
    logic [1:0] prev_clk;
    logic prev_async;
    logic [3:0] sense;
    logic async_sel;
    logic [2:0] line_en;
    logic glob_en;
    logic [2:0] flag;
    logic deep_mode;
    logic [3:0] startup;
    iopx_state_e st;
    logic [4:0] wdt_cnt;
    logic lvl_samp;
    logic [3:0] su_cnt;
    logic [31:0] rdata;
    logic slverr;
  } iopx_state_s;

endpackage

// >>> core/iopx_top.sv
// I/O ports with external interrupt and wake-up logic behind an APB slave
`timescale 1ns/100ps
`include "iopx_cfg.svh"

module iopx_top (
  input wire logic clk,
  input wire logic rstn,
  input wire iopx_pkg::iopx_apb_req_s apb_req,
  output iopx_pkg::iopx_apb_rsp_s apb_rsp,
  input wire logic [3:0][7:0] pin_in,
  output iopx_pkg::iopx_pin_drv_s pin_drv,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  output logic cpu_run
);

  iopx_pkg::iopx_state_s r_reg;
  iopx_pkg::iopx_state_s r_next;

  // ============================================================
  // Helpers
  function automatic logic edge_hit(input logic [1:0] sense, input logic prev,
                                    input logic cur);
    logic hit;
    hit = 1'b0;
    case (sense)
      `IOPX_SENSE_ANY: hit = prev ^ cur;
      `IOPX_SENSE_FALL: hit = prev & ~cur;
      `IOPX_SENSE_RISE: hit = ~prev & cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] port_addr(input int p, input logic [7:0] ofs);
    return 8'(p * `IOPX_PORT_STRIDE) + ofs;
  endfunction

  // ============================================================
  // Next state
  logic [2:0] cur;
  logic [2:0] ev;
  logic [1:0] lvl_low;
  logic [2:0] clr;
  logic io_run;
  logic setup;
  logic wr;
  logic hit;
  logic tick;
  logic samp_now;
  logic [31:0] rd;
  iopx_pkg::iopx_state_e st_now;

  always_comb begin
    r_next = r_reg;
    cur = '0;
    ev = '0;
    lvl_low = '0;
    clr = '0;
    hit = 1'b0;
    rd = '0;
    tick = 1'b0;
    samp_now = 1'b0;
    st_now = r_reg.st;
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

    // Pin synchronisers; direction does not gate the input path
    r_next.sync1 = pin_in;
    r_next.sync2 = r_reg.sync1;
    cur[0] = r_reg.sync2[`IOPX_FIRST_PORT][`IOPX_FIRST_BIT];
    cur[1] = r_reg.sync2[`IOPX_SECOND_PORT][`IOPX_SECOND_BIT];
    cur[2] = r_reg.sync2[`IOPX_ASYNC_PORT][`IOPX_ASYNC_BIT];

    // I/O clock runs awake and in idle only
    io_run = (r_reg.st == iopx_pkg::IOPX_ST_AWAKE) ||
             (r_reg.st == iopx_pkg::IOPX_ST_IDLE);

    // Clocked edge detection of lines one and two
    if (io_run) begin
      r_next.prev_clk = cur[1:0];
      ev[0] = edge_hit(r_reg.sense[`IOPX_SENSE_FIRST_LSB +: 2],
                       r_reg.prev_clk[0], cur[0]);
      ev[1] = edge_hit(r_reg.sense[`IOPX_SENSE_SECOND_LSB +: 2],
                       r_reg.prev_clk[1], cur[1]);
    end

    // Async line edge, live in every state
    r_next.prev_async = cur[2];
    ev[2] = r_reg.async_sel ? (~r_reg.prev_async & cur[2]) :
                              (r_reg.prev_async & ~cur[2]);

    // Low level detect, live in every state
    lvl_low[0] = (r_reg.sense[`IOPX_SENSE_FIRST_LSB +: 2] == `IOPX_SENSE_LOW) &
                 ~cur[0];
    lvl_low[1] = (r_reg.sense[`IOPX_SENSE_SECOND_LSB +: 2] == `IOPX_SENSE_LOW) &
                 ~cur[1];

    // ----------------------------------------------------------
    // APB: read data captured in setup, write taken in access
    for (int p = 0; p < 4; p++) begin
      if (apb_req.paddr == port_addr(p, `IOPX_OFS_LATCH)) begin
        hit = 1'b1;
        rd = {24'h000000, r_reg.latch[p]};
        if (wr) begin
          r_next.latch[p] = apb_req.pwdata[7:0];
        end
      end
      if (apb_req.paddr == port_addr(p, `IOPX_OFS_DIR)) begin
        hit = 1'b1;
        rd = {24'h000000, r_reg.dir[p]};
        if (wr) begin
          r_next.dir[p] = apb_req.pwdata[7:0];
        end
      end
      if (apb_req.paddr == port_addr(p, `IOPX_OFS_PINS)) begin
        hit = 1'b1;
        rd = {24'h000000, r_reg.sync2[p]};
      end
    end
    case (apb_req.paddr)
      `IOPX_ADDR_SENSE: begin
        hit = 1'b1;
        rd = {27'h0000000, r_reg.async_sel, r_reg.sense};
        if (wr) begin
          r_next.sense = apb_req.pwdata[3:0];
          r_next.async_sel = apb_req.pwdata[`IOPX_ASYNC_SEL_BIT];
        end
      end
      `IOPX_ADDR_ENABLE: begin
        hit = 1'b1;
        rd = {24'h000000, r_reg.glob_en, 4'h0, r_reg.line_en};
        if (wr) begin
          r_next.line_en = apb_req.pwdata[2:0];
          r_next.glob_en = apb_req.pwdata[`IOPX_GLOBAL_EN_BIT];
        end
      end
      `IOPX_ADDR_FLAGS: begin
        hit = 1'b1;
        rd = {29'h00000000, r_reg.flag};
        if (wr) begin
          clr = apb_req.pwdata[2:0];
        end
      end
      `IOPX_ADDR_POWER: begin
        hit = 1'b1;
        rd = {22'h000000, r_reg.st, r_reg.startup, 3'h0, r_reg.deep_mode};
        if (wr) begin
          r_next.deep_mode = apb_req.pwdata[`IOPX_PWR_MODE_BIT];
          r_next.startup = apb_req.pwdata[`IOPX_PWR_STARTUP_LSB +: 4];
          if (apb_req.pwdata[`IOPX_PWR_GO_BIT] &&
              r_reg.st == iopx_pkg::IOPX_ST_AWAKE) begin
            st_now = apb_req.pwdata[`IOPX_PWR_MODE_BIT] ? iopx_pkg::IOPX_ST_DEEP :
                                                          iopx_pkg::IOPX_ST_IDLE;
          end
        end
      end
      default: begin
      end
    endcase
    if (setup) begin
      r_next.rdata = hit ? rd : 32'h00000000;
      r_next.slverr = ~hit;
    end

    // ----------------------------------------------------------
    // Pending flags: set wins over clear, held clear in level mode
    clr = clr | irq_ack;
    for (int i = 0; i < 3; i++) begin
      r_next.flag[i] = (r_reg.flag[i] & ~clr[i]) | ev[i];
    end
    for (int i = 0; i < 2; i++) begin
      if (lvl_low[i] || r_reg.sense[2*i +: 2] == `IOPX_SENSE_LOW) begin
        r_next.flag[i] = 1'b0;
      end
    end

    // ----------------------------------------------------------
    // Watchdog tick and wake sequencing
    if (r_reg.st == iopx_pkg::IOPX_ST_DEEP || r_reg.st == iopx_pkg::IOPX_ST_START) begin
      if (r_reg.wdt_cnt == 5'(`IOPX_WDT_CYCLES - 1)) begin
        r_next.wdt_cnt = '0;
        tick = 1'b1;
      end else begin
        r_next.wdt_cnt = r_reg.wdt_cnt + 5'h01;
      end
    end else begin
      r_next.wdt_cnt = '0;
      r_next.lvl_samp = 1'b0;
    end
    samp_now = |(r_reg.line_en[1:0] & lvl_low);

    case (r_reg.st)
      iopx_pkg::IOPX_ST_AWAKE: begin
        r_next.st = st_now;
      end
      iopx_pkg::IOPX_ST_IDLE: begin
        if (|(r_reg.line_en & (r_reg.flag | {1'b0, lvl_low}))) begin
          r_next.st = iopx_pkg::IOPX_ST_AWAKE;
        end
      end
      iopx_pkg::IOPX_ST_DEEP: begin
        if (tick) begin
          r_next.lvl_samp = samp_now;
        end
        if (tick && samp_now && r_reg.lvl_samp) begin
          r_next.st = iopx_pkg::IOPX_ST_START;
          r_next.su_cnt = '0;
        end else if (r_reg.line_en[2] && r_reg.flag[2]) begin
          r_next.st = iopx_pkg::IOPX_ST_START;
          r_next.su_cnt = '0;
        end
      end
      iopx_pkg::IOPX_ST_START: begin
        // Wake regardless of level; request then follows the live pin
        if (tick) begin
          if (r_reg.su_cnt >= r_reg.startup) begin
            r_next.st = iopx_pkg::IOPX_ST_AWAKE;
          end else begin
            r_next.su_cnt = r_reg.su_cnt + 4'h1;
          end
        end
      end
      default: begin
        r_next.st = iopx_pkg::IOPX_ST_AWAKE;
      end
    endcase
  end

  // ============================================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '{
        latch: {4{`IOPX_LATCH_RST}},
        dir: {4{`IOPX_DIR_RST}},
        sync1: '0,
        sync2: '0,
        prev_clk: '0,
        prev_async: 1'b0,
        sense: `IOPX_SENSE_RST,
        async_sel: 1'b0,
        line_en: '0,
        glob_en: 1'b0,
        flag: '0,
        deep_mode: 1'b0,
        startup: `IOPX_STARTUP_RST,
        st: iopx_pkg::IOPX_ST_AWAKE,
        wdt_cnt: '0,
        lvl_samp: 1'b0,
        su_cnt: '0,
        rdata: '0,
        slverr: 1'b0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // ============================================================
  // Outputs
  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = r_reg.slverr;
    apb_rsp.prdata = r_reg.rdata;
    pin_drv.out = r_reg.latch;
    pin_drv.oe = r_reg.dir;
    cpu_run = r_reg.st == iopx_pkg::IOPX_ST_AWAKE;
    for (int i = 0; i < 3; i++) begin
      irq_req[i] = r_reg.glob_en & r_reg.line_en[i] & io_run &
                   (r_reg.flag[i] | (i < 2 ? lvl_low[i[0]] : 1'b0));
    end
  end

endmodule
